// ==== hw/alert_monitor_pkg.sv ====
// package of the four-channel temperature alert monitor
// assumes a 16-bit register port and signed process values in tenths of a degree
package alert_monitor_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_ACTION = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_DEF_BASE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 8'h10;
  localparam int CH_STRIDE_SHIFT = 3;
  // per-channel limit slots
  localparam logic [2:0] SLOT_LL = 3'h0;
  localparam logic [2:0] SLOT_LU = 3'h1;
  localparam logic [2:0] SLOT_UL = 3'h2;
  localparam logic [2:0] SLOT_UU = 3'h3;
  localparam logic [2:0] SLOT_RATE_UP = 3'h4;
  localparam logic [2:0] SLOT_RATE_LO = 3'h5;
  localparam logic [2:0] SLOT_CYCLE = 3'h6;

  // ==========================================================================
  // fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_BIT = 3;
  localparam int EN_RATE_LSB = 4;
  localparam int DEF_PROC_UP = 2;
  localparam int DEF_PROC_LO = 3;
  localparam int DEF_RATE_UP = 4;
  localparam int DEF_RATE_LO = 5;

  // ==========================================================================
  // reset values: enable code 1 means disabled
  localparam logic [DATA_W-1:0] ENABLE_RST = 16'h00FF;
  localparam logic [DATA_W-1:0] CYCLE_RST = 16'h0001;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic signed [DATA_W-1:0] TENTHS = 16'sh000A;
  localparam logic signed [DATA_W-1:0] HALF = 16'sh0005;
  localparam int LAMP_HALF_PERIOD = 50000000;

  typedef enum logic [2:0] {
    MODE_STANDARD,
    MODE_HC_NORMAL,
    MODE_HC_EXPANDED,
    MODE_MIX_NORMAL,
    MODE_MIX_EXPANDED
  } ctrl_mode_e;

  typedef enum logic [1:0] {
    KIND_STD,
    KIND_HC,
    KIND_NONE
  } loop_kind_e;

  typedef struct packed {
    logic signed [DATA_W-1:0] lowerLower;
    logic signed [DATA_W-1:0] lowerUpper;
    logic signed [DATA_W-1:0] upperLower;
    logic signed [DATA_W-1:0] upperUpper;
    logic signed [DATA_W-1:0] rateUpper;
    logic signed [DATA_W-1:0] rateLower;
  } limits_s;

  typedef struct packed {
    logic procUpper;
    logic procLower;
    logic rateUpper;
    logic rateLower;
  } alerts_s;

endpackage

// ==== hw/alert_channel.sv ====
// one channel's process alarm with hysteresis and rate alarm
// assumes detect pulses once per detection cycle and pv is already rounded if needed
`timescale 1ns/1ps
module alert_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic signed [alert_monitor_pkg::DATA_W-1:0] pv,
  input wire logic detect,
  input wire logic procEnable,
  input wire logic rateEnable,
  input wire alert_monitor_pkg::limits_s limits,
  output alert_monitor_pkg::alerts_s alerts
);

  logic procUp_q;
  logic procLo_q;
  logic rateUp_q;
  logic rateLo_q;
  logic prevValid_q;
  logic signed [alert_monitor_pkg::DATA_W-1:0] prev_q;
  logic signed [alert_monitor_pkg::DATA_W:0] diff;

  // ==========================================================================
  // process alarm; only the value, clearing procEnable or rst_b clears it, no error reset path
  always_ff @(posedge clk) begin
    if (!rst_b || !procEnable) begin
      procUp_q <= 1'b0;
      procLo_q <= 1'b0;
    end else begin
      if (pv >= limits.upperUpper) begin
        procUp_q <= 1'b1;
      end else if (pv < limits.upperLower) begin
        procUp_q <= 1'b0;
      end
      if (pv <= limits.lowerLower) begin
        procLo_q <= 1'b1;
      end else if (pv > limits.lowerUpper) begin
        procLo_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // rate alarm; one extra bit keeps the difference from wrapping
  assign diff = {pv[alert_monitor_pkg::DATA_W-1], pv}
      - {prev_q[alert_monitor_pkg::DATA_W-1], prev_q};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_q <= '0;
      prevValid_q <= 1'b0;
    end else if (detect) begin
      prev_q <= pv;
      prevValid_q <= rateEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !rateEnable) begin
      rateUp_q <= 1'b0;
      rateLo_q <= 1'b0;
    end else if (detect && prevValid_q) begin
      // set and clear both follow the latest difference
      rateUp_q <= diff >= $signed({limits.rateUpper[alert_monitor_pkg::DATA_W-1],
          limits.rateUpper});
      rateLo_q <= diff <= $signed({limits.rateLower[alert_monitor_pkg::DATA_W-1],
          limits.rateLower});
    end
  end

  assign alerts = '{procUpper: procUp_q, procLower: procLo_q,
                    rateUpper: rateUp_q, rateLower: rateLo_q};

endmodule

// ==== hw/temperature_alert_monitor.sv ====
// four-channel temperature alert monitor with control mode and output steering
// assumes pv, sampleTick, loop demands and loopError come from logic on clk
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module temperature_alert_monitor #(
  parameter int LAMP_HALF_CYCLES = alert_monitor_pkg::LAMP_HALF_PERIOD
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [alert_monitor_pkg::ADDR_W-1:0] regAddr,
  input wire logic [alert_monitor_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [alert_monitor_pkg::DATA_W-1:0] regRdData,
  input wire logic [alert_monitor_pkg::NUM_CH-1:0][alert_monitor_pkg::DATA_W-1:0] processValue,
  input wire logic sampleTick,
  input wire logic [alert_monitor_pkg::NUM_CH-1:0] loopRaise,
  input wire logic [alert_monitor_pkg::NUM_CH-1:0] loopLower,
  input wire logic loopError,
  output logic [alert_monitor_pkg::NUM_CH-1:0] alertFlag,
  output logic alarmLamp,
  output logic [alert_monitor_pkg::NUM_CH-1:0] heatOut,
  output logic [alert_monitor_pkg::NUM_CH-1:0] coolOut,
  output logic irq
);

  localparam int NCH = alert_monitor_pkg::NUM_CH;
  localparam int DW = alert_monitor_pkg::DATA_W;
  localparam int CHW = $clog2(NCH);

  // ==========================================================================
  // helpers
  function automatic alert_monitor_pkg::loop_kind_e loopKind(
    input alert_monitor_pkg::ctrl_mode_e mode,
    input int ch
  );
    alert_monitor_pkg::loop_kind_e kind;
    kind = alert_monitor_pkg::KIND_STD;
    case (mode)
      alert_monitor_pkg::MODE_STANDARD: kind = alert_monitor_pkg::KIND_STD;
      alert_monitor_pkg::MODE_HC_NORMAL: begin
        // loops three and four only measure
        kind = (ch < 2) ? alert_monitor_pkg::KIND_HC
            : alert_monitor_pkg::KIND_NONE;
      end
      alert_monitor_pkg::MODE_HC_EXPANDED: kind = alert_monitor_pkg::KIND_HC;
      alert_monitor_pkg::MODE_MIX_NORMAL: begin
        // loop two only measures here
        if (ch == 0) begin
          kind = alert_monitor_pkg::KIND_HC;
        end else if (ch == 1) begin
          kind = alert_monitor_pkg::KIND_NONE;
        end else begin
          kind = alert_monitor_pkg::KIND_STD;
        end
      end
      alert_monitor_pkg::MODE_MIX_EXPANDED: begin
        kind = (ch < 2) ? alert_monitor_pkg::KIND_HC
            : alert_monitor_pkg::KIND_STD;
      end
      default: kind = alert_monitor_pkg::KIND_NONE;
    endcase
    return kind;
  endfunction

  // round half away from zero to a whole degree, still in tenths
  function automatic logic signed [DW-1:0] roundDegree(
    input logic signed [DW-1:0] v
  );
    logic signed [DW-1:0] mag;
    logic signed [DW-1:0] q;
    // most negative code has no magnitude
    mag = v[DW-1] ? -v : v;
    q = ((mag + alert_monitor_pkg::HALF) / alert_monitor_pkg::TENTHS)
        * alert_monitor_pkg::TENTHS;
    return v[DW-1] ? -q : q;
  endfunction

  // ==========================================================================
  // registers
  alert_monitor_pkg::ctrl_mode_e mode_q;
  logic resOneDegree_q;
  logic [DW-1:0] enable_q;
  logic [NCH-1:0] actionForward_q;
  logic [NCH-1:0] irqStat_q;
  logic [NCH-1:0] irqMask_q;
  logic [DW-1:0] rdData_q;
  alert_monitor_pkg::limits_s limits_q [NCH];
  logic [DW-1:0] cycle_q [NCH];

  logic chanSel;
  logic [CHW-1:0] chanIdx;
  logic [2:0] slot;
  alert_monitor_pkg::alerts_s alerts [NCH];
  logic [NCH-1:0] detect;
  logic [NCH-1:0] anyAlert;
  logic [NCH-1:0] anyAlertPrev_q;
  logic [DW-1:0] defWord [NCH];

  // eight slots a channel; the last is spare
  assign chanSel = regAddr >= alert_monitor_pkg::ADDR_CH_BASE
      && regAddr < alert_monitor_pkg::ADDR_CH_BASE + (NCH << alert_monitor_pkg::CH_STRIDE_SHIFT);
  assign chanIdx = CHW'((regAddr - alert_monitor_pkg::ADDR_CH_BASE)
      >> alert_monitor_pkg::CH_STRIDE_SHIFT);
  assign slot = regAddr[2:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= alert_monitor_pkg::MODE_STANDARD;
      resOneDegree_q <= 1'b0;
    end else if (regWr && regAddr == alert_monitor_pkg::ADDR_CTRL) begin
      // codes above 4 are ignored and the old mode kept
      if (regWrData[alert_monitor_pkg::CTRL_MODE_LSB +: 3]
          <= alert_monitor_pkg::MODE_MAX) begin
        mode_q <= alert_monitor_pkg::ctrl_mode_e'(
            regWrData[alert_monitor_pkg::CTRL_MODE_LSB +: 3]);
      end
      resOneDegree_q <= regWrData[alert_monitor_pkg::CTRL_RES_BIT];
    end
  end

  // bits 3:0 process, 7:4 rate alarms
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_q <= alert_monitor_pkg::ENABLE_RST;
    end else if (regWr && regAddr == alert_monitor_pkg::ADDR_ENABLE) begin
      enable_q <= regWrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      actionForward_q <= '0;
      irqMask_q <= '0;
    end else if (regWr) begin
      // set bit: forward action, cooling
      if (regAddr == alert_monitor_pkg::ADDR_ACTION) begin
        actionForward_q <= regWrData[NCH-1:0];
      end
      if (regAddr == alert_monitor_pkg::ADDR_IRQ_MASK) begin
        irqMask_q <= regWrData[NCH-1:0];
      end
    end
  end

  // ==========================================================================
  // per-channel limits, detection cycle counters and alarm units
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gCh
      logic [DW-1:0] tick_q;
      logic signed [DW-1:0] pvUsed;

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          limits_q[g] <= '0;
          cycle_q[g] <= alert_monitor_pkg::CYCLE_RST;
        end else if (regWr && chanSel && chanIdx == CHW'(g)) begin
          case (slot)
            alert_monitor_pkg::SLOT_LL: limits_q[g].lowerLower <= regWrData;
            alert_monitor_pkg::SLOT_LU: limits_q[g].lowerUpper <= regWrData;
            alert_monitor_pkg::SLOT_UL: limits_q[g].upperLower <= regWrData;
            alert_monitor_pkg::SLOT_UU: limits_q[g].upperUpper <= regWrData;
            alert_monitor_pkg::SLOT_RATE_UP: limits_q[g].rateUpper <= regWrData;
            alert_monitor_pkg::SLOT_RATE_LO: limits_q[g].rateLower <= regWrData;
            alert_monitor_pkg::SLOT_CYCLE: begin
              // a zero cycle would detect on every tick just like one, so it is stored as one
              cycle_q[g] <= (regWrData == '0) ? alert_monitor_pkg::CYCLE_RST
                  : regWrData;
            end
            default: ;
          endcase
        end
      end

      // one detection every cycle_q sample ticks
      // a cycle cut below the count fires next tick
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          tick_q <= '0;
        end else if (sampleTick) begin
          tick_q <= detect[g] ? '0 : tick_q + 1'b1;
        end
      end
      assign detect[g] = sampleTick
          && (tick_q + 1'b1 >= cycle_q[g]);

      // rounding feeds both alarms alike
      assign pvUsed = resOneDegree_q ? roundDegree(processValue[g])
          : processValue[g];

      alert_channel uChan (
        .clk(clk),
        .rst_b(rst_b),
        .pv(pvUsed),
        .detect(detect[g]),
        .procEnable(!enable_q[g]),
        .rateEnable(!enable_q[alert_monitor_pkg::EN_RATE_LSB + g]),
        .limits(limits_q[g]),
        .alerts(alerts[g])
      );

      always_comb begin
        defWord[g] = '0;
        defWord[g][alert_monitor_pkg::DEF_PROC_UP] = alerts[g].procUpper;
        defWord[g][alert_monitor_pkg::DEF_PROC_LO] = alerts[g].procLower;
        defWord[g][alert_monitor_pkg::DEF_RATE_UP] = alerts[g].rateUpper;
        defWord[g][alert_monitor_pkg::DEF_RATE_LO] = alerts[g].rateLower;
      end

      // flag holds while any alert type of the channel stays active
      assign anyAlert[g] = |alerts[g];

      // output steering per loop kind
      always_comb begin
        heatOut[g] = 1'b0;
        coolOut[g] = 1'b0;
        case (loopKind(mode_q, g))
          alert_monitor_pkg::KIND_STD: begin
            // single output; the other direction is just that output off
            if (actionForward_q[g]) begin
              coolOut[g] = loopLower[g];
            end else begin
              heatOut[g] = loopRaise[g];
            end
          end
          alert_monitor_pkg::KIND_HC: begin
            // opposing demands: both outputs off
            heatOut[g] = loopRaise[g] && !loopLower[g];
            coolOut[g] = loopLower[g] && !loopRaise[g];
          end
          default: ;
        endcase
      end
    end
  endgenerate

  assign alertFlag = anyAlert;

  // ==========================================================================
  // interrupt status: set on a new alert, cleared by reading, set wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      anyAlertPrev_q <= '0;
    end else begin
      anyAlertPrev_q <= anyAlert;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStat_q <= '0;
    end else begin
      // rising flags only: one interrupt per onset
      irqStat_q <= ((regRd && regAddr == alert_monitor_pkg::ADDR_IRQ_STAT)
          ? '0 : irqStat_q) | (anyAlert & ~anyAlertPrev_q);
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // ==========================================================================
  // alarm lamp; the flashing error indication takes priority
  localparam int BCW = $clog2(LAMP_HALF_CYCLES + 1);
  logic [BCW-1:0] blinkCnt_q;
  logic blink_q;

  // a new error restarts the flash lit
  always_ff @(posedge clk) begin
    if (!rst_b || !loopError) begin
      blinkCnt_q <= '0;
      blink_q <= 1'b1;
    end else if (blinkCnt_q == BCW'(LAMP_HALF_CYCLES - 1)) begin
      blinkCnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + 1'b1;
    end
  end

  assign alarmLamp = loopError ? blink_q : |anyAlert;

  // ==========================================================================
  // read port: data stand one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData_q <= '0;
    end else if (regRd) begin
      rdData_q <= '0;
      if (chanSel) begin
        case (slot)
          alert_monitor_pkg::SLOT_LL: rdData_q <= limits_q[chanIdx].lowerLower;
          alert_monitor_pkg::SLOT_LU: rdData_q <= limits_q[chanIdx].lowerUpper;
          alert_monitor_pkg::SLOT_UL: rdData_q <= limits_q[chanIdx].upperLower;
          alert_monitor_pkg::SLOT_UU: rdData_q <= limits_q[chanIdx].upperUpper;
          alert_monitor_pkg::SLOT_RATE_UP: rdData_q <= limits_q[chanIdx].rateUpper;
          alert_monitor_pkg::SLOT_RATE_LO: rdData_q <= limits_q[chanIdx].rateLower;
          alert_monitor_pkg::SLOT_CYCLE: rdData_q <= cycle_q[chanIdx];
          default: rdData_q <= '0;
        endcase
      end else if (regAddr >= alert_monitor_pkg::ADDR_DEF_BASE
          && regAddr < alert_monitor_pkg::ADDR_DEF_BASE + NCH) begin
        rdData_q <= defWord[CHW'(regAddr
            - alert_monitor_pkg::ADDR_DEF_BASE)];
      end else begin
        case (regAddr)
          alert_monitor_pkg::ADDR_CTRL: begin
            rdData_q[alert_monitor_pkg::CTRL_MODE_LSB +: 3] <= mode_q;
            rdData_q[alert_monitor_pkg::CTRL_RES_BIT] <= resOneDegree_q;
          end
          alert_monitor_pkg::ADDR_ENABLE: rdData_q <= enable_q;
          alert_monitor_pkg::ADDR_ACTION: rdData_q[NCH-1:0] <= actionForward_q;
          alert_monitor_pkg::ADDR_IRQ_STAT: rdData_q[NCH-1:0] <= irqStat_q;
          alert_monitor_pkg::ADDR_IRQ_MASK: rdData_q[NCH-1:0] <= irqMask_q;
          alert_monitor_pkg::ADDR_FLAGS: rdData_q[NCH-1:0] <= anyAlert;
          default: rdData_q <= '0;
        endcase
      end
    end
  end

  assign regRdData = rdData_q;

endmodule

// ==== verification/ramp_sensor.sv ====
// far-side sensor model: per-channel process values and the sample tick
// assumes the bench loads start values and ramp steps on clk
`timescale 1ns/1ps
module ramp_sensor #(
  parameter int TICK_PERIOD = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic setEn,
  input wire logic [3:0][15:0] setValue,
  input wire logic [3:0][15:0] step,
  output logic sampleTick,
  output logic [3:0][15:0] processValue
);
  // ==========
  // sample tick
  logic [7:0] tickCnt_q;
  always_ff @(posedge clk) begin
    if (!rst_b || tickCnt_q == 8'(TICK_PERIOD - 1)) tickCnt_q <= 8'h00;
    else tickCnt_q <= tickCnt_q + 8'h01;
  end
  assign sampleTick = rst_b && (tickCnt_q == 8'(TICK_PERIOD - 1));
  // ==========
  // temperature ramp: steps only on a tick, like a real sampled sensor; setEn loads a new value at once
  always_ff @(posedge clk) begin
    if (!rst_b) processValue <= '0;
    else if (setEn) processValue <= setValue;
    else if (sampleTick) begin
      for (int c = 0; c < 4; c++) processValue[c] <= processValue[c] + step[c];
    end
  end
endmodule

// ==== verification/temperature_alert_monitor_asserts.sv ====
// port checker of the alert monitor
// assumes it is bound to the top module and shares its lamp parameter
`timescale 1ns/1ps
module temperature_alert_monitor_chk #(
  parameter int LAMP_HALF_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic [3:0][15:0] processValue,
  input wire logic sampleTick,
  input wire logic [3:0] loopRaise,
  input wire logic [3:0] loopLower,
  input wire logic loopError,
  input wire logic [3:0] alertFlag,
  input wire logic alarmLamp,
  input wire logic [3:0] heatOut,
  input wire logic [3:0] coolOut,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========
  // helpers: lamp hold time under error, and age of the last alert cause
  logic [7:0] flashCnt_q;
  logic lampPrev_q;
  logic [3:0] sinceCause_q;
  logic [3:0][15:0] pvPrev_q;
  always_ff @(posedge clk) begin
    lampPrev_q <= alarmLamp;
    if (!rst_b || !loopError || alarmLamp != lampPrev_q) flashCnt_q <= 8'h00;
    else if (flashCnt_q != 8'hFF) flashCnt_q <= flashCnt_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    pvPrev_q <= processValue;
    if (!rst_b || sampleTick || regWr || processValue != pvPrev_q) sinceCause_q <= 4'h0;
    else if (sinceCause_q != 4'hF) sinceCause_q <= sinceCause_q + 4'h1;
  end
  // ==========
  // assertions
  a_outputs_exclusive: assert property ((heatOut & coolOut) == 4'h0)
    else $error("heat and cool on together");
  a_heat_has_demand: assert property ((heatOut & ~loopRaise) == 4'h0)
    else $error("heat without raise demand");
  a_cool_has_demand: assert property ((coolOut & ~loopLower) == 4'h0)
    else $error("cool without lower demand");
  a_lamp_shows_alert: assert property (
    !loopError && !$past(loopError) && !$past(loopError, 2) && $stable(alertFlag)
    |-> alarmLamp == (|alertFlag)) else $error("steady lamp disagrees with flags");
  a_lamp_flashes: assert property (
    loopError |-> flashCnt_q <= 8'(LAMP_HALF_CYCLES + 2)) else $error("lamp not flashing");
  a_flash_not_fast: assert property (
    $changed(alarmLamp) && loopError && $past(loopError) && $past(loopError, 2)
    |-> $past(alarmLamp) == $past(alarmLamp, 2)) else $error("lamp toggles too fast");
  a_flags_hold_quiet: assert property (
    (!sampleTick && !regWr && $stable(processValue))[*4] |=> $stable(alertFlag))
    else $error("alert moved without cause");
  a_change_has_cause: assert property (
    !$stable(alertFlag) |-> sinceCause_q <= 4'h4) else $error("alert change too late");
  c_flag_rise: cover property ($rose(|alertFlag));
  c_flash_on_alert: cover property (loopError && (|alertFlag));
  c_irq_seen: cover property (irq);
endmodule

bind temperature_alert_monitor temperature_alert_monitor_chk #(
  .LAMP_HALF_CYCLES(LAMP_HALF_CYCLES)
) chk (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .processValue(processValue),
  .sampleTick(sampleTick), .loopRaise(loopRaise), .loopLower(loopLower),
  .loopError(loopError), .alertFlag(alertFlag), .alarmLamp(alarmLamp),
  .heatOut(heatOut), .coolOut(coolOut), .irq(irq)
);

// ==== verification/temperature_alert_monitor_bench.sv ====
// self-checking bench of the alert monitor
// assumes the design, the sensor model and the checker compile first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module temperature_alert_monitor_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic [3:0][15:0] processValue;
  logic sampleTick;
  logic [3:0] loopRaise = 4'h0;
  logic [3:0] loopLower = 4'h0;
  logic loopError = 1'b0;
  logic [3:0] alertFlag;
  logic alarmLamp;
  logic [3:0] heatOut;
  logic [3:0] coolOut;
  logic irq;
  logic setEn = 1'b0;
  logic [3:0][15:0] setValue = '0;
  logic [3:0][15:0] step = '0;
  int fails = 0;
  int cmp_count = 0;

  temperature_alert_monitor #(.LAMP_HALF_CYCLES(4)) DUT (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .processValue(processValue),
    .sampleTick(sampleTick), .loopRaise(loopRaise), .loopLower(loopLower),
    .loopError(loopError), .alertFlag(alertFlag), .alarmLamp(alarmLamp),
    .heatOut(heatOut), .coolOut(coolOut), .irq(irq)
  );
  ramp_sensor #(.TICK_PERIOD(8)) SENS (
    .clk(clk), .rst_b(rst_b), .setEn(setEn), .setValue(setValue), .step(step),
    .sampleTick(sampleTick), .processValue(processValue)
  );

  always #2.5 clk = ~clk;

  // ==========
  // bus and stimulus tasks
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(nm, e, regRdData)
  endtask
  task automatic setPv(input logic [15:0] v);
    @(posedge clk);
    setValue[0] <= v;
    setEn <= 1'b1;
    @(posedge clk);
    setEn <= 1'b0;
  endtask
  task automatic waitFlag(input logic e);
    int n;
    n = 0;
    while (alertFlag[0] !== e && n < 200) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n == 200) begin
      fails++;
      $display("BAD flag wait expected %h seen %h", e, alertFlag[0]);
      give_verdict();
    end
  endtask
  task automatic pvRow(input logic [15:0] v, input logic [15:0] d);
    setPv(v);
    idle(2);
    `CHK("flag", {3'b000, d != 16'h0000}, alertFlag)
    rdChk("def", 8'h08, d);
  endtask
  // expected steering of one channel: {heat, cool}
  function automatic logic [1:0] steer(int m, int c, logic act, logic r, logic l);
    int kind;
    if (m == 0) kind = 0;
    else if (m == 2 || c == 0) kind = 1;
    else if (c == 1) kind = (m == 3) ? 2 : 1;
    else kind = (m == 1) ? 2 : 0;
    case (kind)
      0: return act ? {1'b0, l} : {r, 1'b0};
      1: return {r & !l, l & !r};
      default: return 2'b00;
    endcase
  endfunction

  // ==========
  // scenarios
  task automatic t_reset();
    rdChk("ctrl", 8'h00, 16'h0000);
    rdChk("enable", 8'h01, 16'h00FF);
    rdChk("cycle", 8'h16, 16'h0001);
    rdChk("unmapped", 8'h07, 16'h0000);
    wr(8'h05, 16'h000F);
    rdChk("flags ro", 8'h05, 16'h0000);
    for (int c = 0; c < 4; c++) rdChk("def rst", 8'h08 + 8'(c), 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_process();
    logic [15:0] pv [12] = '{16'd500, 16'd1000, 16'd950, 16'd900, 16'd899, 16'd100,
      16'd200, 16'd201, 16'd994, 16'd995, 16'd896, 16'd894};
    logic [15:0] df [12] = '{0, 4, 4, 4, 0, 8, 8, 0, 0, 4, 4, 0};
    setValue[1] <= 16'd1000;
    wr(8'h10, 16'd100);
    wr(8'h11, 16'd200);
    wr(8'h12, 16'd900);
    wr(8'h13, 16'd1000);
    wr(8'h04, 16'h0001);
    wr(8'h01, 16'h00FE);
    for (int i = 0; i < 12; i++) begin
      if (i == 8) begin
        `CHK("irq", 1'b1, irq)
        rdChk("stat", 8'h03, 16'h0001);
        idle(1);
        `CHK("irq clr", 1'b0, irq)
        wr(8'h00, 16'h0008);
      end
      pvRow(pv[i], df[i]);
    end
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0000);
    $display("test process done");
  endtask
  task automatic t_rate();
    logic [15:0] st [5] = '{16'd30, 16'd25, 16'd24, 16'hFFE7, 16'd0};
    logic [15:0] df [5] = '{16'h0010, 16'h0010, 0, 16'h0020, 0};
    wr(8'h16, 16'h0002);
    wr(8'h14, 16'd50);
    wr(8'h15, 16'hFFCE);
    setPv(16'd0);
    wr(8'h01, 16'h00EF);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      step[0] <= st[i];
      idle(40);
      waitFlag(df[i] != 16'h0000);
      rdChk("rate def", 8'h08, df[i]);
    end
    $display("test rate done");
  endtask
  task automatic t_both();
    int n;
    logic last;
    wr(8'h01, 16'h00EE);
    setPv(16'd1000);
    @(posedge clk);
    step[0] <= 16'd30;
    idle(40);
    rdChk("both def", 8'h08, 16'h0014);
    @(posedge clk);
    step[0] <= 16'd0;
    idle(40);
    rdChk("proc def", 8'h08, 16'h0004);
    `CHK("flag held", 4'h1, alertFlag)
    `CHK("lamp held", 1'b1, alarmLamp)
    @(posedge clk);
    loopError <= 1'b1;
    n = 0;
    last = alarmLamp;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (alarmLamp !== last) n++;
      last = alarmLamp;
    end
    `CHK("flashing", 1'b1, n >= 8)
    @(posedge clk);
    loopError <= 1'b0;
    wr(8'h01, 16'h00FF);
    idle(3);
    `CHK("off flag", 4'h0, alertFlag)
    `CHK("off lamp", 1'b0, alarmLamp)
    rdChk("off def", 8'h08, 16'h0000);
    $display("test combined done");
  endtask
  task automatic t_steer();
    logic [1:0] hc;
    logic [1:0] j;
    for (int m = 0; m < 5; m++) begin
      for (int a = 0; a < 2; a++) begin
        wr(8'h00, 16'(m));
        wr(8'h02, a ? 16'h000F : 16'h0000);
        for (int k = 0; k < 4; k++) begin
          @(posedge clk);
          for (int c = 0; c < 4; c++) begin
            j = 2'((c + k) % 4);
            loopRaise[c] <= j[0];
            loopLower[c] <= j[1];
          end
          idle(1);
          for (int c = 0; c < 4; c++) begin
            hc = steer(m, c, a[0], loopRaise[c], loopLower[c]);
            `CHK("heat", hc[1], heatOut[c])
            `CHK("cool", hc[0], coolOut[c])
          end
        end
      end
    end
    wr(8'h00, 16'h000D);
    rdChk("bad mode", 8'h00, 16'h000C);
    $display("test steering done");
  endtask

  // ==========
  // run control
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_process();
    t_rate();
    t_both();
    t_steer();
    give_verdict();
  end
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("BAD run length expected %h seen %h", 1'b0, 1'b1);
    give_verdict();
  end
endmodule
